// >>> design/vpa_pkg.sv
// vpa_pkg: shared constants and types of the virtual phy negotiation emulator.
// assumes a 100 MHz system clock and a 16-bit register port with byte addresses.
package vpa_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// byte addresses of the register port
	localparam logic [7:0] ADDR_BASIC_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_BASIC_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ADVERT       = 8'h10;
	localparam logic [7:0] ADDR_PARTNER      = 8'h14;
	localparam logic [7:0] ADDR_EXPANSION    = 8'h18;
	localparam logic [7:0] ADDR_MANUAL_FC    = 8'h20;
	localparam logic [7:0] ADDR_CHIP_RESET   = 8'h24;
	// basic control fields
	localparam int CTRL_RESET   = 15;
	localparam int CTRL_SPEED   = 13;
	localparam int CTRL_NEG_EN  = 12;
	localparam int CTRL_RESTART = 9;
	localparam int CTRL_DUPLEX  = 8;
	localparam logic [15:0] CTRL_RESET_VAL = 16'h3100;
	localparam logic [15:0] CTRL_WR_MASK   = 16'h3100;
	// basic status: fixed abilities plus the completion bit
	localparam int STAT_NEG_DONE = 5;
	localparam logic [15:0] STAT_FIXED = 16'h780D;
	// advertisement and partner ability fields
	localparam int ADV_10HD  = 5;
	localparam int ADV_10FD  = 6;
	localparam int ADV_100HD = 7;
	localparam int ADV_100FD = 8;
	localparam int ADV_PAUSE = 10;
	localparam int ADV_ASYM  = 11;
	localparam logic [15:0] ADV_RESET_VAL = 16'h0DE1;
	localparam logic [15:0] ADV_WR_MASK   = 16'h0DE0;
	localparam logic [15:0] SELECTOR      = 16'h0001;
	// expansion fields
	localparam int EXP_PARTNER_ABLE = 0;
	localparam int EXP_PAGE_RX      = 1;
	// manual flow control fields
	localparam int MFC_RX     = 0;
	localparam int MFC_TX     = 1;
	localparam int MFC_SELECT = 2;
	localparam int MFC_ACT_RX = 3;
	localparam int MFC_ACT_TX = 4;
	localparam int MFC_ACT_FD = 5;
	localparam logic [15:0] MFC_WR_MASK = 16'h0007;
	// chip reset control field
	localparam int CHIP_VIRT_SOFT_RESET_BIT = 1;
	// answer for unmapped or refused reads
	localparam logic [15:0] READ_NONE    = 16'h0000;
	localparam logic [15:0] READ_REFUSED = 16'hFFFF;
	// timing
	localparam int CHIP_RST_US    = 102;
	localparam int CHIP_RST_CYC   = (CHIP_RST_US * 1000) / CLK_PERIOD_NS;
	localparam int BASIC_RST_CYC  = 4;

	typedef enum logic [4:0] {
		NEG_IDLE   = 5'h01,
		NEG_DONE1  = 5'h02,
		NEG_PAGE   = 5'h04,
		NEG_RESULT = 5'h08,
		NEG_HOLD   = 5'h10
	} vpa_neg_state_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
		logic        via_mii;
	} vpa_req_t;

	typedef struct packed {
		logic speed_100;
		logic full_duplex;
		logic rx_pause;
		logic tx_pause;
	} vpa_link_t;
endpackage

// >>> design/vpa_emulator.sv
// vpa_emulator: emulated negotiation, forced and mac-mode link setting of a virtual phy.
// assumes pins and straps arrive asynchronously; reload and digital reset are clk pulses.
//
// Notes on behaviour
// - negotiate only while enable bit set
// - restart on every reset, restart bit, reload
// - complete, then page received, then result
// - and local and partner technology bits
// - priority 100 full, 100 half, 10 full, 10 half
// - advertisement resets with all four bits set
// - later advertisement writes wait for rerun
// - partner abilities from static pin and straps
// - no next page, remote fault, t4
// - common ability: able bit, partner abilities
// - none common: half duplex, strap speed
// - disabled: force speed, duplex from control
// - pause resolved per ethernet pause rules
// - partner pause mirrors local pause request
// - manual flow register overrides, reports state
// - mac mode duplex follows pin versus strap
// - mac mode disabled: duplex from control bit
// - mac mode refuses management frame access
// - chip reset bit resets, clears after 102us
// - local is management side, partner fabric
// - control reset bit reads zero when done
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
module vpa_emulator #(
	parameter int CHIP_RST_CYCLES = vpa_pkg::CHIP_RST_CYC
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// asynchronous pins and straps
	input  wire logic               hw_reset_n,
	input  wire logic               port0_duplex_input,
	input  wire logic               duplex_pol_strap,
	input  wire logic               speed_strap,
	input  wire logic               mac_mode,
	// chip events from the clk domain
	input  wire logic               digital_reset,
	input  wire logic               eeprom_reload,
	// register port
	input  wire vpa_pkg::vpa_req_t  req,
	output logic             [15:0] rdata,
	// port 0 settings
	output vpa_pkg::vpa_link_t      port0_link,
	output logic                    neg_busy
);
	// pin synchronisers: first stage read only by second
	// no reset: they fill while rst is held (two clocks at least), so the
	// strap capture at release sees the real pins, not a reset pattern
	logic [4:0] sync_a;
	logic [4:0] sync_b;
	always_ff @(posedge clk) begin
		sync_a <= {hw_reset_n, port0_duplex_input, duplex_pol_strap, speed_strap, mac_mode};
		sync_b <= sync_a;
	end
	logic hw_rst_s;
	logic dup_pin_s;
	logic pol_s;
	logic spd_s;
	logic mac_s;
	assign hw_rst_s  = ~sync_b[4];
	assign dup_pin_s = sync_b[3];
	assign pol_s     = sync_b[2];
	assign spd_s     = sync_b[1];
	assign mac_s     = sync_b[0];

	// straps captured after release, on hardware reset and on reload
	logic strap_load;
	logic cap_dup;
	logic cap_pol;
	logic cap_spd;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_load <= 1'b1;
			cap_dup    <= 1'b1;
			cap_pol    <= 1'b1;
			cap_spd    <= 1'b1;
		end else if (hw_rst_s || eeprom_reload) begin
			strap_load <= 1'b1;
		end else if (strap_load) begin
			// changing pins later does not restart negotiation
			strap_load <= 1'b0;
			cap_dup    <= dup_pin_s;
			cap_pol    <= pol_s;
			cap_spd    <= spd_s;
		end
	end

	// register access, refused through management frames in mac mode
	logic acc_ok;
	logic wr_ok;
	assign acc_ok = !(mac_s && req.via_mii);
	assign wr_ok  = req.wr && acc_ok;

	// software resets
	logic [15:0] chip_cnt;
	logic [2:0]  basic_cnt;
	logic        chip_rst_bit;
	logic        basic_rst_on;
	assign chip_rst_bit = (chip_cnt != 16'h0000);
	assign basic_rst_on = (basic_cnt != 3'h0);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chip_cnt <= 16'h0000;
		end else if (wr_ok && req.addr == vpa_pkg::ADDR_CHIP_RESET &&
			req.wdata[vpa_pkg::CHIP_VIRT_SOFT_RESET_BIT] && !chip_rst_bit) begin
			chip_cnt <= 16'(CHIP_RST_CYCLES);
		end else if (chip_rst_bit) begin
			chip_cnt <= chip_cnt - 16'h0001;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			basic_cnt <= 3'h0;
		end else if (wr_ok && req.addr == vpa_pkg::ADDR_BASIC_CTRL &&
			req.wdata[vpa_pkg::CTRL_RESET] && !basic_rst_on) begin
			basic_cnt <= 3'(vpa_pkg::BASIC_RST_CYC);
		end else if (basic_rst_on) begin
			basic_cnt <= basic_cnt - 3'h1;
		end
	end

	// held reset of the virtual phy registers
	logic vphy_hold;
	assign vphy_hold = chip_rst_bit || basic_rst_on || hw_rst_s || digital_reset;

	// control, advertisement and manual flow registers
	logic [15:0] ctrl;
	logic [15:0] advert;
	logic [15:0] manual_fc;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= vpa_pkg::CTRL_RESET_VAL;
		end else if (vphy_hold) begin
			ctrl <= vpa_pkg::CTRL_RESET_VAL;
		end else if (wr_ok && req.addr == vpa_pkg::ADDR_BASIC_CTRL) begin
			ctrl <= req.wdata & vpa_pkg::CTRL_WR_MASK;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			advert <= vpa_pkg::ADV_RESET_VAL;
		end else if (vphy_hold) begin
			advert <= vpa_pkg::ADV_RESET_VAL;
		end else if (wr_ok && req.addr == vpa_pkg::ADDR_ADVERT) begin
			// next page, remote fault and t4 stay zero
			advert <= (req.wdata & vpa_pkg::ADV_WR_MASK) | vpa_pkg::SELECTOR;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			manual_fc <= 16'h0000;
		end else if (vphy_hold) begin
			manual_fc <= 16'h0000;
		end else if (wr_ok && req.addr == vpa_pkg::ADDR_MANUAL_FC) begin
			manual_fc <= req.wdata & vpa_pkg::MFC_WR_MASK;
		end
	end
	logic neg_enable_bit;
	assign neg_enable_bit = ctrl[vpa_pkg::CTRL_NEG_EN];

	// restart request stays pending until a run takes it
	logic restart_pend;
	logic restart_set;
	logic run_start;
	assign restart_set = vphy_hold || eeprom_reload ||
		(wr_ok && req.addr == vpa_pkg::ADDR_BASIC_CTRL && req.wdata[vpa_pkg::CTRL_RESTART]);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			restart_pend <= 1'b1;
		end else if (restart_set) begin
			restart_pend <= 1'b1;
		end else if (run_start) begin
			restart_pend <= 1'b0;
		end
	end

	// emulated fabric partner, seen from the management side
	logic [3:0] partner_tech;
	logic [3:0] common;
	logic [3:0] pd_tech;
	always_comb begin
		// order: 100fd 100hd 10fd 10hd
		if (cap_spd) begin
			partner_tech = (cap_dup == cap_pol) ? 4'hC : 4'h4;
		end else begin
			partner_tech = (cap_dup == cap_pol) ? 4'h3 : 4'h1;
		end
	end
	assign common  = partner_tech & {advert[vpa_pkg::ADV_100FD], advert[vpa_pkg::ADV_100HD],
		advert[vpa_pkg::ADV_10FD], advert[vpa_pkg::ADV_10HD]};
	assign pd_tech = cap_spd ? 4'h4 : 4'h1;

	// pause resolution with mirrored partner pause bits
	logic loc_sym;
	logic loc_asym;
	logic par_sym;
	logic par_asym;
	assign loc_sym  = advert[vpa_pkg::ADV_PAUSE];
	assign loc_asym = advert[vpa_pkg::ADV_ASYM];
	assign par_sym  = loc_sym;
	assign par_asym = loc_asym;

	// highest common choice and full result
	vpa_pkg::vpa_link_t highest_common_choice;
	logic               next_able;
	always_comb begin
		highest_common_choice = '0;
		next_able = 1'b1;
		if (common[3]) begin
			highest_common_choice.speed_100   = 1'b1;
			highest_common_choice.full_duplex = 1'b1;
		end else if (common[2]) begin
			highest_common_choice.speed_100   = 1'b1;
		end else if (common[1]) begin
			highest_common_choice.full_duplex = 1'b1;
		end else if (common[0]) begin
			highest_common_choice.speed_100   = 1'b0;
		end else begin
			// parallel detect fallback
			next_able = 1'b0;
			highest_common_choice.speed_100 = cap_spd;
		end
		if (highest_common_choice.full_duplex) begin
			highest_common_choice.tx_pause = (loc_sym && par_sym) ||
				(!loc_sym && loc_asym && par_sym && par_asym);
			highest_common_choice.rx_pause = (loc_sym && par_sym) ||
				(loc_sym && loc_asym && !par_sym && par_asym);
		end
	end

	// negotiation sequence and its committed, readable copy
	vpa_pkg::vpa_neg_state_t neg_state;
	logic              step_done;
	logic              step_page;
	logic              pub_done;
	logic              pub_page;
	logic              pub_able;
	logic [3:0]        pub_tech;
	vpa_pkg::vpa_link_t neg_result;
	assign run_start = (neg_state == vpa_pkg::NEG_IDLE || neg_state == vpa_pkg::NEG_HOLD) &&
		restart_pend && neg_enable_bit && !vphy_hold;
	assign neg_busy  = (neg_state != vpa_pkg::NEG_IDLE) && (neg_state != vpa_pkg::NEG_HOLD);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			neg_state <= vpa_pkg::NEG_IDLE;
			step_done <= 1'b0;
			step_page <= 1'b0;
		end else if (vphy_hold) begin
			neg_state <= vpa_pkg::NEG_IDLE;
			step_done <= 1'b0;
			step_page <= 1'b0;
		end else begin
			case (neg_state)
				vpa_pkg::NEG_IDLE, vpa_pkg::NEG_HOLD: begin
					if (run_start) begin
						neg_state <= vpa_pkg::NEG_DONE1;
						step_done <= 1'b0;
						step_page <= 1'b0;
					end
				end
				vpa_pkg::NEG_DONE1: begin
					step_done <= 1'b1;
					neg_state <= vpa_pkg::NEG_PAGE;
				end
				vpa_pkg::NEG_PAGE: begin
					step_page <= 1'b1;
					neg_state <= vpa_pkg::NEG_RESULT;
				end
				vpa_pkg::NEG_RESULT: begin
					neg_state <= vpa_pkg::NEG_HOLD;
				end
				default: begin
					neg_state <= vpa_pkg::NEG_IDLE;
				end
			endcase
		end
	end
	// status appears all at once; a run in flight shows none of it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pub_done   <= 1'b0;
			pub_page   <= 1'b0;
			pub_able   <= 1'b0;
			pub_tech   <= 4'h0;
			neg_result <= '0;
		end else if (vphy_hold || run_start) begin
			pub_done <= 1'b0;
			pub_page <= 1'b0;
			pub_able <= 1'b0;
			pub_tech <= 4'h0;
		end else if (neg_state == vpa_pkg::NEG_RESULT && step_done && step_page) begin
			// result frozen here; later advert writes wait for a rerun
			pub_done   <= 1'b1;
			pub_page   <= 1'b1;
			pub_able   <= next_able;
			pub_tech   <= next_able ? partner_tech : pd_tech;
			neg_result <= highest_common_choice;
		end
	end

	// effective port 0 setting
	logic               manual_on;
	logic               eff_fd;
	vpa_pkg::vpa_link_t next_link;
	assign manual_on = !neg_enable_bit || manual_fc[vpa_pkg::MFC_SELECT];
	always_comb begin
		if (mac_s && neg_enable_bit) begin
			// not latched: tracks the pin every cycle
			eff_fd = (dup_pin_s == pol_s);
		end else if (!neg_enable_bit) begin
			eff_fd = ctrl[vpa_pkg::CTRL_DUPLEX];
		end else begin
			eff_fd = neg_result.full_duplex;
		end
		next_link.full_duplex = eff_fd;
		next_link.speed_100 = neg_enable_bit ? neg_result.speed_100 :
			ctrl[vpa_pkg::CTRL_SPEED];
		if (manual_on) begin
			next_link.rx_pause = eff_fd && manual_fc[vpa_pkg::MFC_RX];
			next_link.tx_pause = eff_fd && manual_fc[vpa_pkg::MFC_TX];
		end else begin
			next_link.rx_pause = eff_fd && neg_result.rx_pause;
			next_link.tx_pause = eff_fd && neg_result.tx_pause;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port0_link <= '0;
		end else begin
			port0_link <= next_link;
		end
	end

	// read data, one cycle after the strobe
	logic [15:0] next_rdata;
	always_comb begin
		next_rdata = vpa_pkg::READ_NONE;
		if (!acc_ok) begin
			next_rdata = vpa_pkg::READ_REFUSED;
		end else if (req.addr == vpa_pkg::ADDR_BASIC_CTRL) begin
			// restart reads one while pending with the enable bit set; reset bit until done
			next_rdata = ctrl;
			next_rdata[vpa_pkg::CTRL_RESET]   = basic_rst_on;
			next_rdata[vpa_pkg::CTRL_RESTART] = restart_pend && neg_enable_bit;
		end else if (req.addr == vpa_pkg::ADDR_BASIC_STATUS) begin
			next_rdata = vpa_pkg::STAT_FIXED;
			next_rdata[vpa_pkg::STAT_NEG_DONE] = pub_done;
		end else if (req.addr == vpa_pkg::ADDR_ADVERT) begin
			next_rdata = advert;
		end else if (req.addr == vpa_pkg::ADDR_PARTNER) begin
			next_rdata = vpa_pkg::SELECTOR;
			next_rdata[vpa_pkg::ADV_100FD] = pub_tech[3];
			next_rdata[vpa_pkg::ADV_100HD] = pub_tech[2];
			next_rdata[vpa_pkg::ADV_10FD]  = pub_tech[1];
			next_rdata[vpa_pkg::ADV_10HD]  = pub_tech[0];
			next_rdata[vpa_pkg::ADV_PAUSE] = par_sym;
			next_rdata[vpa_pkg::ADV_ASYM]  = par_asym;
		end else if (req.addr == vpa_pkg::ADDR_EXPANSION) begin
			next_rdata[vpa_pkg::EXP_PAGE_RX]      = pub_page;
			next_rdata[vpa_pkg::EXP_PARTNER_ABLE] = pub_able;
		end else if (req.addr == vpa_pkg::ADDR_MANUAL_FC) begin
			// reports active settings, never touches the advertisement
			next_rdata = manual_fc;
			next_rdata[vpa_pkg::MFC_ACT_RX] = port0_link.rx_pause;
			next_rdata[vpa_pkg::MFC_ACT_TX] = port0_link.tx_pause;
			next_rdata[vpa_pkg::MFC_ACT_FD] = port0_link.full_duplex;
		end else if (req.addr == vpa_pkg::ADDR_CHIP_RESET) begin
			next_rdata[vpa_pkg::CHIP_VIRT_SOFT_RESET_BIT] = chip_rst_bit;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 16'h0000;
		end else if (req.rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= 16'h0000;
		end
	end
endmodule

// >>> bench/vpa_emulator_monitor.sv
// vpa_emulator_monitor: port-level checks of the negotiation emulator.
// assumes it is bound into vpa_emulator and sees only its ports.
`timescale 1ns/100ps
module vpa_emulator_monitor #(
	parameter int CHIP_RST_CYCLES = vpa_pkg::CHIP_RST_CYC
) (
	// clock and reset
	input wire logic               clk,
	input wire logic               rst,
	// pins and events
	input wire logic               hw_reset_n,
	input wire logic               mac_mode,
	input wire logic               digital_reset,
	// register port
	input wire vpa_pkg::vpa_req_t  req,
	input wire logic        [15:0] rdata,
	// port 0 settings
	input wire vpa_pkg::vpa_link_t port0_link,
	input wire logic               neg_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// control writes that reach the register; a reset write is left out
	logic ctrl_wr;
	assign ctrl_wr = req.wr && !req.via_mii && !req.wdata[15]
		&& req.addr == vpa_pkg::ADDR_BASIC_CTRL;

	// mac_mode passes a synchroniser, so it must have settled first
	refused_read_a: assert property (
		mac_mode && $past(mac_mode, 3) && req.rd && req.via_mii |=> rdata == 16'hFFFF)
		else $error("mii read in mac mode not refused");
	open_read_a: assert property (
		!mac_mode && !$past(mac_mode, 3) && req.rd |=> rdata != 16'hFFFF)
		else $error("read refused outside mac mode");
	busy_bounded_a: assert property (
		$rose(neg_busy) |-> ##[1:8] !neg_busy)
		else $error("negotiation run too long");
	restart_runs_a: assert property (
		ctrl_wr && req.wdata[12] && req.wdata[9] && hw_reset_n && !digital_reset
		|-> ##[1:10] neg_busy)
		else $error("restart write started no run");
	disabled_idle_a: assert property (
		ctrl_wr && !req.wdata[12] && !neg_busy |=> !neg_busy [*4])
		else $error("run while negotiation disabled");
	forced_link_a: assert property (
		ctrl_wr && !req.wdata[12] |-> ##3
		port0_link.speed_100 == $past(req.wdata[13], 3)
		&& port0_link.full_duplex == $past(req.wdata[8], 3))
		else $error("forced speed or duplex not applied");
	hw_restart_a: assert property (
		$rose(hw_reset_n) |-> ##[1:12] neg_busy)
		else $error("no run after hardware reset");
	digital_restart_a: assert property (
		$rose(digital_reset) |-> ##[1:10] neg_busy)
		else $error("no run after digital reset");

	cover property ($rose(neg_busy));
	cover property (ctrl_wr && !req.wdata[12]);
	cover property (mac_mode && req.rd && req.via_mii);
endmodule

bind vpa_emulator vpa_emulator_monitor #(.CHIP_RST_CYCLES(CHIP_RST_CYCLES)) mon (
	.clk, .rst, .hw_reset_n, .mac_mode, .digital_reset, .req, .rdata, .port0_link,
	.neg_busy);

// >>> bench/vpa_mac_model.sv
// vpa_mac_model: management master on the register port.
// assumes the port samples requests on the rising edge of clk.
`timescale 1ns/100ps
module vpa_mac_model (
	// clock
	input wire logic          clk,
	// register port
	output vpa_pkg::vpa_req_t req
);
	initial req = '0;

	// one strobe cycle; idle fields flip so stale values never look valid
	task automatic access(input logic [7:0] a, input logic [15:0] d, input logic w,
		input logic mii);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: w, rd: !w, via_mii: mii};
		@(posedge clk);
		req <= '{addr: ~a, wdata: ~d, wr: 1'h0, rd: 1'h0, via_mii: ~mii};
	endtask
endmodule

// >>> bench/vpa_emulator_tb.sv
// vpa_emulator_tb: self-checking bench of the negotiation emulator.
// assumes the mac model drives requests; read data is checked one cycle late.
`timescale 1ns/100ps
module vpa_emulator_tb;
	localparam int RC = 20;
	logic               clk;
	logic               rst;
	logic               hw_reset_n;
	logic               pin;
	logic               pol;
	logic               spd;
	logic               mac;
	logic               dig;
	logic               rel;
	vpa_pkg::vpa_req_t  req;
	logic        [15:0] rdata;
	vpa_pkg::vpa_link_t link;
	logic               neg_busy;
	logic               rd_seen = 1'h0;
	logic         [3:0] last_lk;
	logic        [31:0] seed = 32'h4A29;
	logic        [31:0] exp_q[$];
	logic         [3:0] ptab[3] = '{4'hC, 4'h3, 4'h1};
	int                 fail_count = 0;
	int                 samples_checked = 0;
	int                 cycles = 0;

	vpa_emulator #(.CHIP_RST_CYCLES(RC)) DUT (.clk(clk), .rst(rst), .hw_reset_n(hw_reset_n),
		.port0_duplex_input(pin), .duplex_pol_strap(pol), .speed_strap(spd),
		.mac_mode(mac), .digital_reset(dig), .eeprom_reload(rel), .req(req),
		.rdata(rdata), .port0_link(link), .neg_busy(neg_busy));
	vpa_mac_model host (.clk(clk), .req(req));

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic print_verdict();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] e, input logic [15:0] m);
		samples_checked++;
		if ((got & m) !== (e & m)) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, e);
		end
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic mii = 1'h0);
		host.access(a, d, 1'h1, mii);
	endtask

	// the note goes in first, so it is queued before the data appears
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m,
		input logic mii = 1'h0);
		exp_q.push_back({m, e});
		host.access(a, e, 1'h0, mii);
	endtask

	task automatic lk(input logic [3:0] e);
		chk({12'h0, link}, {12'h0, e}, 16'h000F);
	endtask

	// random advertisement, rerun, then a late write that must not count
	task automatic neg_round(input logic [3:0] p);
		logic [3:0]  a;
		logic [3:0]  c;
		logic [3:0]  pt;
		logic [15:0] pv;
		logic        ps;
		logic        fd;
		logic        sp;
		logic        ab;
		seed = xs(seed);
		a = seed[3:0];
		ps = seed[4];
		pv = {4'h0, seed[5], ps, 1'h0, a, 5'h00};
		c = a & p;
		ab = |c;
		fd = c[3] | (!c[2] & c[1]);
		sp = ab ? (c[3] | c[2]) : spd;
		pt = ab ? p : (spd ? 4'h4 : 4'h1);
		last_lk = {sp, fd, fd & ps, fd & ps};
		wr(vpa_pkg::ADDR_ADVERT, pv | 16'h0001);
		wr(vpa_pkg::ADDR_BASIC_CTRL, 16'h1200);
		cyc(8);
		rd(vpa_pkg::ADDR_BASIC_STATUS, 16'h782D, 16'hFFFF);
		rd(vpa_pkg::ADDR_EXPANSION, {14'h0, 1'h1, ab}, 16'h0003);
		rd(vpa_pkg::ADDR_PARTNER, {pv[15:9], pt, 5'h00}, 16'hADE0);
		lk(last_lk);
		wr(vpa_pkg::ADDR_ADVERT, ~pv & 16'h0DE0);
		cyc(4);
		lk(last_lk);
	endtask

	always @(posedge clk) begin
		if (rd_seen) begin
			chk(rdata, exp_q[0][15:0], exp_q[0][31:16]);
			void'(exp_q.pop_front());
		end
		rd_seen <= req.rd;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			print_verdict();
		end
	end

	initial begin
		rst = 1'h1;
		hw_reset_n = 1'h1;
		pin = 1'h1;
		pol = 1'h1;
		spd = 1'h1;
		mac = 1'h0;
		dig = 1'h0;
		rel = 1'h0;
		cyc(4);
		rst <= 1'h0;
		cyc(12);
		rd(vpa_pkg::ADDR_ADVERT, 16'h0DE1, 16'hFFFF);
		rd(vpa_pkg::ADDR_BASIC_CTRL, 16'h3100, 16'hFFFF);
		rd(vpa_pkg::ADDR_EXPANSION, 16'h0003, 16'hFFFF);
		rd(8'h3C, 16'h0000, 16'hFFFF);
		lk(4'hF);
		// straps change only under hardware reset, held well past the synchroniser
		for (int ph = 0; ph < 3; ph++) begin
			hw_reset_n <= 1'h0;
			spd <= (ph == 0);
			pin <= (ph < 2);
			cyc(5);
			hw_reset_n <= 1'h1;
			cyc(12);
			repeat (6) neg_round(ptab[ph]);
		end
		pin <= 1'h1;
		cyc(6);
		lk(last_lk);
		pin <= 1'h0;
		cyc(3);
		wr(vpa_pkg::ADDR_ADVERT, 16'h0D01);
		rel <= 1'h1;
		cyc(1);
		rel <= 1'h0;
		cyc(10);
		rd(vpa_pkg::ADDR_EXPANSION, 16'h0002, 16'hFFFF);
		dig <= 1'h1;
		cyc(2);
		dig <= 1'h0;
		cyc(10);
		rd(vpa_pkg::ADDR_EXPANSION, 16'h0003, 16'hFFFF);
		wr(vpa_pkg::ADDR_ADVERT, 16'h0D01);
		wr(vpa_pkg::ADDR_CHIP_RESET, 16'h0002);
		rd(vpa_pkg::ADDR_CHIP_RESET, 16'h0002, 16'h0002);
		cyc(RC + 12);
		rd(vpa_pkg::ADDR_CHIP_RESET, 16'h0000, 16'h0002);
		rd(vpa_pkg::ADDR_ADVERT, 16'h0DE1, 16'hFFFF);
		wr(vpa_pkg::ADDR_BASIC_CTRL, 16'h9100);
		rd(vpa_pkg::ADDR_BASIC_CTRL, 16'h8000, 16'h8000);
		cyc(12);
		rd(vpa_pkg::ADDR_BASIC_CTRL, 16'h3100, 16'hFFFF);
		wr(vpa_pkg::ADDR_MANUAL_FC, 16'h0003);
		for (int i = 0; i < 4; i++) begin
			wr(vpa_pkg::ADDR_BASIC_CTRL, {2'h0, i[1], 4'h0, i[0], 8'h00});
			cyc(4);
			lk({i[1], i[0], i[0], i[0]});
		end
		rd(vpa_pkg::ADDR_MANUAL_FC, 16'h003B, 16'hFFFF);
		rd(vpa_pkg::ADDR_ADVERT, 16'h0DE1, 16'hFFFF);
		mac <= 1'h1;
		wr(vpa_pkg::ADDR_BASIC_CTRL, 16'h1000);
		for (int i = 0; i < 2; i++) begin
			pin <= i[0];
			cyc(6);
			chk({12'h0, link}, {13'h0, i[0], 2'h0}, 16'h0004);
		end
		rd(vpa_pkg::ADDR_BASIC_CTRL, 16'hFFFF, 16'hFFFF, 1'h1);
		wr(vpa_pkg::ADDR_BASIC_CTRL, 16'h0000, 1'h1);
		rd(vpa_pkg::ADDR_BASIC_CTRL, 16'h1000, 16'hFFFF);
		pin <= 1'h0;
		wr(vpa_pkg::ADDR_BASIC_CTRL, 16'h0100);
		cyc(4);
		chk({12'h0, link}, 16'h0004, 16'h0004);
		wr(vpa_pkg::ADDR_MANUAL_FC, 16'h0007);
		rd(vpa_pkg::ADDR_MANUAL_FC, 16'h003F, 16'hFFFF);
		cyc(4);
		print_verdict();
	end
endmodule
